// [inc/cmq_consts.svh]
// Offsets, field positions, reset values and sizes of the egress queue and AQM block
`ifndef CMQ_CONSTS_SVH
`define CMQ_CONSTS_SVH

`define CMQ_NUM_QUEUES 8
`define CMQ_QUEUE_DEPTH 16
`define CMQ_PTR_W 5
`define CMQ_MIN_QUEUES 4'h2
`define CMQ_MAX_QUEUES 4'h8
`define CMQ_PRIO_MSB 7
`define CMQ_PRIO_LSB 5

`define CMQ_NUM_FLOWS 4
`define CMQ_ADDR_W 8
`define CMQ_REG_CTRL 8'h00
`define CMQ_REG_AQM_CFG 8'h04
`define CMQ_REG_SLEEP 8'h08
`define CMQ_REG_STATUS 8'h0C
`define CMQ_REG_DROPS 8'h10

`define CMQ_CTRL_RESET 4'h8
`define CMQ_DISABLE_RESET 4'h0
`define CMQ_PROV_OFF_RESET 4'h0
`define CMQ_BE_NRT_RESET 4'hF
`define CMQ_CFG_DIS_LSB 0
`define CMQ_CFG_PROV_LSB 4
`define CMQ_CFG_BE_LSB 8

`define CMQ_AQM_RATE_SHIFT 4
`define CMQ_AQM_TARGET 16'h0010
`define CMQ_AQM_STEP 8'h04
`define CMQ_LFSR_SEED 16'hACE1

`endif

// [inc/cmq_pkg.sv]
// Types shared by the egress queue and AQM block
package cmq_pkg;

  typedef struct packed {
    logic [31:0] data;
    logic sop;
    logic eop;
    logic hasHdr;
    logic [7:0] extValue;
  } ds_beat_s;

  typedef struct packed {
    logic [31:0] data;
    logic sop;
    logic eop;
    logic [2:0] queue;
  } ds_out_s;

  typedef struct packed {
    logic valid;
    logic [1:0] flow;
    logic [15:0] depthBytes;
  } aqm_arrival_s;

  typedef struct packed {
    logic valid;
    logic drop;
    logic [1:0] flow;
  } aqm_decision_s;

  typedef enum logic {OUT_IDLE, OUT_SEND} out_state_e;

endpackage : cmq_pkg

// [rtl/cm_priority_queue_aqm.sv]
// Downstream strict-priority egress queues and per-flow upstream AQM control
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "cmq_consts.svh"

// How it works
// - Traffic priority is the top three bits of the extended header value field.
// - At least two egress queues exist for the customer premises port.
// - Each packet's egress queue comes from its header priority.
// - A packet without the extended header is treated as priority zero.
// - Never start a lower queue's packet while a higher queue holds one; the code only defers to a higher queue that holds a whole packet.
// - Queues are numbered by rising priority, zero lowest, seven highest.
// - Two, three and four queue configurations map priorities per the fixed table.
// - Five to eight queue configurations map priorities per the fixed table.
// - AQM stays on for best-effort and polling flows unless provisioned off.
// - Each upstream flow has its own AQM state, uncoupled from others.
// - A per-flow control turns AQM off for that flow alone.
// - AQM is off on all flows while in light sleep mode.
// - Leaving light sleep re-enables AQM from the initial state.
// - Each arrival gets a latency estimate fed to an enqueue-or-drop control law.
module cm_priority_queue_aqm
  import cmq_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire ds_beat_s inBeat,
  input wire logic inValid,
  output logic inReady,
  output ds_out_s outBeat,
  output logic outValid,
  input wire logic outReady,
  input wire aqm_arrival_s aqmIn,
  output aqm_decision_s aqmDec,
  input wire logic [`CMQ_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata
);

  localparam int NQ = `CMQ_NUM_QUEUES;
  localparam int DEPTH = `CMQ_QUEUE_DEPTH;
  localparam int NF = `CMQ_NUM_FLOWS;

  function automatic logic [2:0] mapPrio(input logic [2:0] p, input logic [3:0] n);
    logic [2:0] q;
    q = 3'h0;
    unique case (n)
      4'h2: q = {2'h0, p[2]};
      4'h3: q = (p < 3'h4) ? 3'h0 : ((p < 3'h6) ? 3'h1 : 3'h2);
      4'h4: q = {1'b0, p[2:1]};
      4'h5: q = (p < 3'h4) ? {2'h0, p[1]} :
                ((p == 3'h4) ? 3'h2 : ((p == 3'h5) ? 3'h3 : 3'h4));
      4'h6: q = (p < 3'h2) ? 3'h0 : ((p == 3'h7) ? 3'h5 : 3'(p - 3'h1));
      4'h7: q = (p == 3'h0) ? 3'h0 : 3'(p - 3'h1);
      default: q = p;
    endcase
    return q;
  endfunction : mapPrio

  ////////////////////////////////////////////////////////////////////////////////
  // Two-entry input buffer: a stall at the queues never drops a beat

  ds_beat_s buf0, buf1, next_buf0, next_buf1;
  logic buf0Valid, buf1Valid, next_buf0Valid, next_buf1Valid;
  logic bufPop;

  assign inReady = !buf1Valid;

  always_comb begin
    next_buf0 = buf0;
    next_buf1 = buf1;
    next_buf0Valid = buf0Valid;
    next_buf1Valid = buf1Valid;
    if (bufPop) begin
      next_buf0 = buf1;
      next_buf0Valid = buf1Valid;
      next_buf1Valid = 1'b0;
    end
    if (inValid && inReady) begin
      if (!next_buf0Valid) begin
        next_buf0 = inBeat;
        next_buf0Valid = 1'b1;
      end else begin
        next_buf1 = inBeat;
        next_buf1Valid = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      buf0 <= '0;
      buf1 <= '0;
      buf0Valid <= 1'b0;
      buf1Valid <= 1'b0;
    end else begin
      buf0 <= next_buf0;
      buf1 <= next_buf1;
      buf0Valid <= next_buf0Valid;
      buf1Valid <= next_buf1Valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Queue selection and storage

  logic [3:0] numQueues;
  logic [2:0] beatPrio, curQ, heldQ, next_heldQ;
  logic [32:0] qMem [NQ][DEPTH];
  logic [`CMQ_PTR_W-1:0] wrPtr [NQ], rdPtr [NQ], pktCnt [NQ];
  logic [`CMQ_PTR_W-1:0] next_wrPtr [NQ], next_rdPtr [NQ], next_pktCnt [NQ];
  logic [NQ-1:0] qFull, pending;
  logic enq, deq, deqEop;
  logic [2:0] outQ, next_outQ, pickQ;
  logic [32:0] deqWord;
  out_state_e outState, next_outState;
  ds_out_s next_outBeat;
  logic next_outValid, outLoad, pickFound;

  // Header-less beats carry priority zero
  assign beatPrio = buf0.hasHdr ? buf0.extValue[`CMQ_PRIO_MSB:`CMQ_PRIO_LSB] : 3'h0;
  assign curQ = buf0.sop ? mapPrio(beatPrio, numQueues) : heldQ;
  assign enq = buf0Valid && !qFull[curQ];
  assign bufPop = enq;
  assign next_heldQ = (enq && buf0.sop) ? curQ : heldQ;

  for (genvar g = 0; g < NQ; g++) begin : g_queue
    assign qFull[g] = (wrPtr[g] - rdPtr[g]) == `CMQ_PTR_W'(DEPTH);
    assign pending[g] = pktCnt[g] != '0;
  end

  // Highest queue with a whole packet wins
  always_comb begin
    pickQ = 3'h0;
    pickFound = 1'b0;
    for (int i = 0; i < NQ; i++) begin
      if (pending[i]) begin
        pickQ = 3'(i);
        pickFound = 1'b1;
      end
    end
  end

  assign outLoad = !outValid || outReady;
  assign next_outQ = (outState == OUT_IDLE) ? pickQ : outQ;
  assign deq = outLoad && ((outState == OUT_SEND) || pickFound);
  assign deqWord = qMem[next_outQ][rdPtr[next_outQ][`CMQ_PTR_W-2:0]];
  assign deqEop = deq && deqWord[0];

  always_comb begin
    for (int i = 0; i < NQ; i++) begin
      next_wrPtr[i] = wrPtr[i];
      next_rdPtr[i] = rdPtr[i];
      next_pktCnt[i] = pktCnt[i];
      if (enq && curQ == 3'(i)) begin
        next_wrPtr[i] = wrPtr[i] + 1'b1;
      end
      if (deq && next_outQ == 3'(i)) begin
        next_rdPtr[i] = rdPtr[i] + 1'b1;
      end
      if (enq && buf0.eop && curQ == 3'(i)) begin
        next_pktCnt[i] = next_pktCnt[i] + 1'b1;
      end
      if (deqEop && next_outQ == 3'(i)) begin
        next_pktCnt[i] = next_pktCnt[i] - 1'b1;
      end
    end
    next_outState = outState;
    if (deq) begin
      next_outState = deqEop ? OUT_IDLE : OUT_SEND;
    end
    next_outBeat = outBeat;
    next_outValid = outValid;
    if (outLoad) begin
      next_outValid = deq;
      if (deq) begin
        next_outBeat.data = deqWord[32:1];
        next_outBeat.eop = deqWord[0];
        next_outBeat.sop = outState == OUT_IDLE;
        next_outBeat.queue = next_outQ;
      end
    end
  end

  // Storage has no reset; only pointers decide what is valid
  always_ff @(posedge mclk) begin
    if (enq) begin
      qMem[curQ][wrPtr[curQ][`CMQ_PTR_W-2:0]] <= {buf0.data, buf0.eop};
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NQ; i++) begin
        wrPtr[i] <= '0;
        rdPtr[i] <= '0;
        pktCnt[i] <= '0;
      end
      heldQ <= 3'h0;
      outQ <= 3'h0;
      outState <= OUT_IDLE;
      outBeat <= '0;
      outValid <= 1'b0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      pktCnt <= next_pktCnt;
      heldQ <= next_heldQ;
      outQ <= next_outQ;
      outState <= next_outState;
      outBeat <= next_outBeat;
      outValid <= next_outValid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Upstream AQM, one independent state per flow

  logic [NF-1:0] flowDisable, provOff, beNrt, aqmActive;
  logic lightSleep;
  logic [7:0] prob [NF], next_prob [NF];
  logic [15:0] lfsr, next_lfsr, latEst, drops, next_drops;
  aqm_decision_s next_aqmDec;

  assign aqmActive = beNrt & ~provOff & ~flowDisable & {NF{!lightSleep}};
  assign latEst = aqmIn.depthBytes >> `CMQ_AQM_RATE_SHIFT;
  assign next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};

  always_comb begin
    for (int f = 0; f < NF; f++) begin
      next_prob[f] = prob[f];
      if (!aqmActive[f]) begin
        next_prob[f] = 8'h00;
      end else if (aqmIn.valid && aqmIn.flow == 2'(f)) begin
        if (latEst > `CMQ_AQM_TARGET) begin
          next_prob[f] = (prob[f] > 8'hFF - `CMQ_AQM_STEP) ? 8'hFF : prob[f] + `CMQ_AQM_STEP;
        end else begin
          next_prob[f] = (prob[f] < `CMQ_AQM_STEP) ? 8'h00 : prob[f] - `CMQ_AQM_STEP;
        end
      end
    end
    next_aqmDec.valid = aqmIn.valid;
    next_aqmDec.flow = aqmIn.flow;
    next_aqmDec.drop = aqmIn.valid && aqmActive[aqmIn.flow]
                       && (prob[aqmIn.flow] > lfsr[7:0]);
    next_drops = drops + {15'h0, next_aqmDec.drop};
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int f = 0; f < NF; f++) begin
        prob[f] <= 8'h00;
      end
      lfsr <= `CMQ_LFSR_SEED;
      aqmDec <= '0;
      drops <= 16'h0000;
    end else begin
      prob <= next_prob;
      lfsr <= next_lfsr;
      aqmDec <= next_aqmDec;
      drops <= next_drops;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register port

  logic [3:0] next_numQueues;
  logic [NF-1:0] next_flowDisable, next_provOff, next_beNrt;
  logic next_lightSleep;
  logic [31:0] next_regRdata;

  always_comb begin
    next_numQueues = numQueues;
    next_flowDisable = flowDisable;
    next_provOff = provOff;
    next_beNrt = beNrt;
    next_lightSleep = lightSleep;
    if (regWr) begin
      unique case (regAddr)
        `CMQ_REG_CTRL: begin
          // Clamped so the queue count never falls below two
          next_numQueues = (regWdata[3:0] < `CMQ_MIN_QUEUES) ? `CMQ_MIN_QUEUES :
                           ((regWdata[3:0] > `CMQ_MAX_QUEUES) ? `CMQ_MAX_QUEUES : regWdata[3:0]);
        end
        `CMQ_REG_AQM_CFG: begin
          next_flowDisable = regWdata[`CMQ_CFG_DIS_LSB +: NF];
          next_provOff = regWdata[`CMQ_CFG_PROV_LSB +: NF];
          next_beNrt = regWdata[`CMQ_CFG_BE_LSB +: NF];
        end
        `CMQ_REG_SLEEP: next_lightSleep = regWdata[0];
        default: ;
      endcase
    end
    next_regRdata = 32'h0000_0000;
    if (regRd) begin
      unique case (regAddr)
        `CMQ_REG_CTRL: next_regRdata = {28'h0, numQueues};
        `CMQ_REG_AQM_CFG: next_regRdata = {20'h0, beNrt, provOff, flowDisable};
        `CMQ_REG_SLEEP: next_regRdata = {31'h0, lightSleep};
        `CMQ_REG_STATUS: next_regRdata = {20'h0, aqmActive, pending};
        `CMQ_REG_DROPS: next_regRdata = {16'h0, drops};
        default: next_regRdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      numQueues <= `CMQ_CTRL_RESET;
      flowDisable <= `CMQ_DISABLE_RESET;
      provOff <= `CMQ_PROV_OFF_RESET;
      beNrt <= `CMQ_BE_NRT_RESET;
      lightSleep <= 1'b0;
      regRdata <= 32'h0000_0000;
    end else begin
      numQueues <= next_numQueues;
      flowDisable <= next_flowDisable;
      provOff <= next_provOff;
      beNrt <= next_beNrt;
      lightSleep <= next_lightSleep;
      regRdata <= next_regRdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  no_hdr_zero_a: assert property (enq && buf0.sop && !buf0.hasHdr |-> curQ == 3'h0)
    else $error("header-less packet not sent to queue zero");
  prio_eight_a: assert property (enq && buf0.sop && buf0.hasHdr && numQueues == 4'h8
      |-> curQ == buf0.extValue[7:5])
    else $error("priority bits not used as queue with eight queues");
  two_queue_map_a: assert property (enq && buf0.sop && numQueues == 4'h2
      |-> curQ == {2'h0, beatPrio[2]})
    else $error("two-queue mapping wrong");
  strict_prio_a: assert property (deq && outState == OUT_IDLE
      |-> (pending >> (32'(pickQ) + 1)) == '0)
    else $error("lower queue started while higher one waits");
  queue_floor_a: assert property (numQueues >= 4'h2)
    else $error("fewer than two queues configured");
  sleep_off_a: assert property (lightSleep |-> aqmActive == '0 ##1 !aqmDec.drop)
    else $error("AQM active during light sleep");
  sleep_reset_a: assert property ($fell(lightSleep) |-> prob[0] == '0 && prob[3] == '0)
    else $error("AQM state not initial after light sleep");
  flow_off_a: assert property (aqmIn.valid && flowDisable[aqmIn.flow]
      |=> aqmDec.valid && !aqmDec.drop)
    else $error("disabled flow saw a drop");
  decision_a: assert property (aqmIn.valid
      |=> aqmDec.valid && aqmDec.flow == $past(aqmIn.flow))
    else $error("arrival got no decision");
  pkt_lock_a: assert property (outState == OUT_SEND |=> outQ == $past(outQ))
    else $error("queue changed inside a packet");

  pkt_out_c: cover property (outValid && outReady && outBeat.eop);
  drop_c: cover property (aqmDec.drop);
  sleep_exit_c: cover property (lightSleep ##1 !lightSleep);
  stall_c: cover property (inValid && !inReady);

endmodule : cm_priority_queue_aqm
`default_nettype wire

// [dv/headend_src.sv]
// Headend-side source model that feeds tagged downstream packets into the block
`timescale 1ns/100ps
`default_nettype none
module headend_src
  import cmq_pkg::*;
(
  input wire logic mclk,
  input wire logic inReady,
  output ds_beat_s inBeat,
  output logic inValid
);
  initial begin
    inBeat = '0;
    inValid = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Beats hold until taken; one idle cycle between packets keeps each strobe edge clean
  task automatic send_pkt(input logic hasHdr, input logic [2:0] prio, input int beats,
                          input logic [31:0] base);
    for (int i = 0; i < beats; i++) begin
      inBeat.data <= base + i;
      inBeat.sop <= (i == 0);
      inBeat.eop <= (i == beats - 1);
      inBeat.hasHdr <= hasHdr;
      // Low bits and the absent-header value carry junk that must be ignored
      inBeat.extValue <= hasHdr ? {prio, 5'h15} : {~prio, 5'h0A};
      inValid <= 1'b1;
      @(posedge mclk);
      while (inReady !== 1'b1) begin
        @(posedge mclk);
      end
    end
    inValid <= 1'b0;
    inBeat.data <= ~(base + beats - 1);
    inBeat.extValue <= ~inBeat.extValue;
    @(posedge mclk);
  endtask : send_pkt
endmodule : headend_src
`default_nettype wire

// [dv/cm_priority_queue_aqm_tb_top.sv]
// Self-checking bench for the egress queues and upstream AQM control
`timescale 1ns/100ps
`default_nettype none
`include "cmq_consts.svh"
module cm_priority_queue_aqm_tb_top
  import cmq_pkg::*;
;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  ds_beat_s inBeat;
  logic inValid;
  logic inReady;
  logic outValid;
  logic outReady = 1'b0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  ds_out_s outBeat;
  aqm_arrival_s aqmIn = '0;
  aqm_decision_s aqmDec;
  logic [`CMQ_ADDR_W-1:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic [31:0] regRdata;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int drops;
  logic dr;
  // Queue per priority, one nibble each, priority zero leftmost; rows are queue counts
  logic [31:0] qMap [2:8] = '{32'h00001111, 32'h00001122, 32'h00112233, 32'h00112344,
                              32'h00123455, 32'h00123456, 32'h01234567};

  always #12.5 mclk = ~mclk;

  cm_priority_queue_aqm dut_u (.mclk(mclk), .arst_n(arst_n), .inBeat(inBeat),
    .inValid(inValid), .inReady(inReady), .outBeat(outBeat), .outValid(outValid),
    .outReady(outReady), .aqmIn(aqmIn), .aqmDec(aqmDec), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  headend_src src_u (.mclk(mclk), .inReady(inReady), .inBeat(inBeat), .inValid(inValid));

  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string w, input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk(w, e, regRdata & m);
  endtask : rd_chk

  task automatic aqm(input logic [1:0] fl, input logic [15:0] dp, output logic drop);
    @(posedge mclk);
    aqmIn <= '{valid: 1'b1, flow: fl, depthBytes: dp};
    @(posedge mclk);
    aqmIn.valid <= 1'b0;
    #1;
    chk("aqmDec.valid", 32'h1, {31'h0, aqmDec.valid});
    chk("aqmDec.flow", {30'h0, fl}, {30'h0, aqmDec.flow});
    drop = aqmDec.drop;
  endtask : aqm

  task automatic recv(input logic [31:0] d, input logic [2:0] q, input logic s = 1'b1,
                      input logic e = 1'b1);
    int n;
    n = 0;
    @(negedge mclk);
    while (outValid !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    chk("outValid", 32'h1, {31'h0, outValid});
    chk("outBeat.data", d, outBeat.data);
    chk("outBeat.queue", {29'h0, q}, {29'h0, outBeat.queue});
    chk("outBeat.sop", {31'h0, s}, {31'h0, outBeat.sop});
    chk("outBeat.eop", {31'h0, e}, {31'h0, outBeat.eop});
    @(posedge mclk);
  endtask : recv

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    @(negedge mclk);
    chk("resetIdle", 32'h4, {29'h0, inReady, outValid, aqmDec.valid});
    rd_chk("ctrl", `CMQ_REG_CTRL, 32'h8, 32'hFFFFFFFF);
    rd_chk("aqmCfg", `CMQ_REG_AQM_CFG, 32'hF00, 32'hFFFFFFFF);
    rd_chk("sleep", `CMQ_REG_SLEEP, 32'h0, 32'hFFFFFFFF);
    rd_chk("drops", `CMQ_REG_DROPS, 32'h0, 32'hFFFFFFFF);
    rd_chk("unmapped", 8'h20, 32'h0, 32'hFFFFFFFF);
    reg_wr(`CMQ_REG_CTRL, 32'h1);
    rd_chk("ctrlLow", `CMQ_REG_CTRL, 32'h2, 32'hF);
    reg_wr(`CMQ_REG_CTRL, 32'h9);
    rd_chk("ctrlHigh", `CMQ_REG_CTRL, 32'h8, 32'hF);
    outReady <= 1'b1;
    // Every queue count against every priority, ninth packet without header
    for (int n = 2; n <= 8; n++) begin
      reg_wr(`CMQ_REG_CTRL, n);
      for (int p = 0; p < 9; p++) begin
        src_u.send_pkt(p < 8, p[2:0], 1, 32'h100 * n + p);
        recv(32'h100 * n + p, qMap[n][(7 - p % 8) * 4 +: 3]);
      end
    end
    outReady <= 1'b0;
    fork
      for (int i = 0; i < 20; i++) src_u.send_pkt(1'b1, 3'h3, 1, 32'h300 + i);
    join_none
    repeat (80) @(posedge mclk);
    @(negedge mclk);
    chk("inReadyFull", 32'h0, {31'h0, inReady});
    @(posedge mclk);
    outReady <= 1'b1;
    for (int i = 0; i < 20; i++) recv(32'h300 + i, 3'h3);
    outReady <= 1'b0;
    src_u.send_pkt(1'b1, 3'h1, 2, 32'hA0);
    src_u.send_pkt(1'b1, 3'h1, 1, 32'hB0);
    src_u.send_pkt(1'b1, 3'h6, 1, 32'hC0);
    repeat (10) @(posedge mclk);
    rd_chk("pending", `CMQ_REG_STATUS, 32'h42, 32'hFF);
    outReady <= 1'b1;
    recv(32'hA0, 3'h1, 1'b1, 1'b0);
    recv(32'hA1, 3'h1, 1'b0, 1'b1);
    recv(32'hC0, 3'h6);
    recv(32'hB0, 3'h1);
    rd_chk("aqmActive", `CMQ_REG_STATUS, 32'hF00, 32'hF00);
    reg_wr(`CMQ_REG_AQM_CFG, 32'hF40);
    rd_chk("aqmActive", `CMQ_REG_STATUS, 32'hB00, 32'hF00);
    reg_wr(`CMQ_REG_AQM_CFG, 32'hF02);
    rd_chk("aqmActive", `CMQ_REG_STATUS, 32'hD00, 32'hF00);
    drops = 0;
    for (int i = 0; i < 80; i++) begin
      aqm(2'h0, 16'hFFFF, dr);
      drops += dr;
      aqm(2'h1, 16'hFFFF, dr);
      chk("flow1Drop", 32'h0, {31'h0, dr});
    end
    chk("dropsSeen", 32'h1, 32'(drops > 0));
    rd_chk("dropCount", `CMQ_REG_DROPS, drops, 32'hFFFF);
    reg_wr(`CMQ_REG_AQM_CFG, 32'hF00);
    aqm(2'h1, 16'h0000, dr);
    chk("flow1Fresh", 32'h0, {31'h0, dr});
    reg_wr(`CMQ_REG_SLEEP, 32'h1);
    rd_chk("aqmSleep", `CMQ_REG_STATUS, 32'h000, 32'hF00);
    aqm(2'h0, 16'hFFFF, dr);
    chk("sleepDrop", 32'h0, {31'h0, dr});
    reg_wr(`CMQ_REG_SLEEP, 32'h0);
    rd_chk("aqmWake", `CMQ_REG_STATUS, 32'hF00, 32'hF00);
    aqm(2'h0, 16'hFFFF, dr);
    chk("wakeDrop", 32'h0, {31'h0, dr});
    stop_test();
  end
endmodule : cm_priority_queue_aqm_tb_top
`default_nettype wire
